// *** src/hwsr_top.sv ***
// Purpose: Host window onto the sample and link-data channel words.
// Assumes: Bit strobes, frame syncs and line levels are on i_clk.
// Notes: Com area and link banks are forwarded, not held here.
`timescale 1ns/1ps

module hwsr_chan
  import hwsr_pkg::*;
#(
  parameter bit IS_TX = 1'b0,
  parameter bit AUDIO = 1'b1
)(
  input wire logic i_clk,              // Core clock
  input wire logic i_rst_n,            // Synchronised reset
  input wire hwsr_chcfg_t i_cfg,       // Slot placement
  input wire logic i_bit_stb,          // One line bit time
  input wire logic [2:0] i_fsync,      // Frame start pulses
  input wire logic [NLINE-1:0] i_line, // Line levels
  input wire logic [31:0] i_load,      // Word to send or inject
  output logic [31:0] o_word,          // Captured or sent word
  output logic o_bit,                  // Transmit bit
  output logic o_oe,                   // Driving the line
  output logic o_evt                   // Transfer event pulse
);
  logic [9:0] pos_reg, pos_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [31:0] sr_reg, sr_next;
  logic [31:0] word_reg, word_next;
  logic evt_reg, evt_next;
  logic fs, in_slot, shift;
  logic [9:0] pos_now, start;
  logic [8:0] len;
  logic [10:0] slot_end;
  logic [5:0] unit, cnt_inc;
  // Slot window, shifting and event timing
  always_comb
  begin
    if (i_cfg.fsel == FS_RX)
      fs = i_fsync[FS_RX];
    else if (i_cfg.fsel == FS_TX)
      fs = i_fsync[FS_TX];
    else
      fs = i_fsync[FS_TDM];
    start = i_cfg.start;
    if (start == '0)
      start = POS_FIRST;
    else if (start > START_MAX)
      start = START_MAX;
    len = i_cfg.len;
    if (len == '0)
      len = LEN_MIN;
    if (AUDIO && len > LEN_AUDIO_MAX)
      len = LEN_AUDIO_MAX;
    else if (len > LEN_LINK_MAX)
      len = LEN_LINK_MAX;
    // Unit is the count in count mode, the slot in frame mode
    if (i_cfg.frame_mode)
      unit = (len > LEN_AUDIO_MAX) ? UNIT_MAX : len[5:0];
    else if (i_cfg.icnt == '0)
      unit = UNIT_MIN;
    else if (i_cfg.icnt > UNIT_MAX)
      unit = UNIT_MAX;
    else
      unit = i_cfg.icnt;
    // A frame start in the same cycle as a bit makes it bit one
    pos_now = fs ? POS_FIRST : pos_reg;
    slot_end = {1'b0, start} + {2'h0, len};
    in_slot = ({1'b0, pos_now} >= {1'b0, start}) &&
              ({1'b0, pos_now} < slot_end);
    shift = i_bit_stb && in_slot;
    cnt_inc = cnt_reg + UNIT_MIN;
    pos_next = pos_now;
    if (i_bit_stb && pos_now != POS_IDLE)
      pos_next = pos_now + POS_FIRST;
    cnt_next = fs ? '0 : cnt_reg;
    sr_next = sr_reg;
    word_next = word_reg;
    if (shift)
    begin
      // MSB leaves first, MSB arrives first
      if (IS_TX)
        sr_next = {sr_reg[30:0], 1'b0};
      else
        sr_next = {sr_reg[30:0], i_line[i_cfg.line]};
      cnt_next = cnt_inc;
    end
    if (i_cfg.frame_mode)
      evt_next = fs;
    else
      evt_next = shift && (cnt_inc >= unit);
    if (evt_next)
    begin
      cnt_next = '0;
      if (IS_TX)
      begin
        // Right-aligned word, pushed up so its top bit goes first
        word_next = i_load;
        sr_next = i_load << (UNIT_MAX - unit);
      end
      else
        word_next = sr_next & (ALL_ONES >> (UNIT_MAX - unit));
    end
  end
  // Channel state registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pos_reg <= POS_IDLE;
      cnt_reg <= '0;
      sr_reg <= '0;
      word_reg <= '0;
      evt_reg <= 1'b0;
    end
    else
    begin
      pos_reg <= pos_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      word_reg <= word_next;
      evt_reg <= evt_next;
    end
  end
  assign o_word = word_reg;
  assign o_bit = sr_reg[31];
  assign o_oe = IS_TX && in_slot;
  assign o_evt = evt_reg;
endmodule : hwsr_chan

module hwsr_top
  import hwsr_pkg::*;
(
  input wire logic i_clk,                      // Core clock, 250 MHz
  input wire logic i_resetn,                   // Async reset, low
  input wire logic [7:0] i_host_ad,            // Host bus level
  output logic [7:0] o_host_ad,                // Host bus read data
  output logic o_host_ad_oe,                   // High while driving
  input wire logic i_host_cs_n,                // Chip select, low
  input wire logic i_host_wr_n,                // Write strobe, low
  input wire logic i_host_rd_n,                // Read strobe, low
  input wire logic i_host_ale,                 // Address latch
  input wire logic i_host_owns_link_bank_first,  // Bank one to host
  input wire logic i_host_owns_link_bank_second, // Bank two to host
  input wire logic [7:0] i_dsp_addr,           // Low byte of 30xxh
  input wire logic i_dsp_wr,                   // DSP write pulse
  input wire logic i_dsp_rd,                   // DSP read pulse
  input wire logic [15:0] i_dsp_wdata,         // DSP write half
  output logic [15:0] o_dsp_rdata,             // DSP read half
  output hwsr_ext_t o_ext,                     // Forwarded access
  input wire logic [7:0] i_ext_rdata,          // Forwarded read byte
  input wire hwsr_chcfg_t [NCH-1:0] i_cfg,     // Channel placement
  input wire logic i_bit_stb,                  // One line bit time
  input wire logic i_tdm_frame_sync,           // TDM frame start
  input wire logic i_rx_frame_sync,            // Rx frame start
  input wire logic i_tx_frame_sync,            // Tx frame start
  input wire logic [NLINE-1:0] i_line,         // Line levels in
  output logic [NLINE-1:0] o_line,             // Line levels out
  output logic [NLINE-1:0] o_line_oe,          // Line drive enables
  output logic [31:0] o_link_rx_load_first,    // Injected rx word 1
  output logic [31:0] o_link_rx_load_second,   // Injected rx word 2
  output logic [NCH-1:0] o_status,             // Sticky statuses
  input wire logic [NCH-1:0] i_status_clr,     // Status clear pulses
  input wire logic [NCH-1:0] i_host_irq_mask,  // 1 routes to host
  input wire logic [NCH-1:0] i_dsp_irq_mask,   // 1 routes to DSP
  output logic o_host_priority_irq,            // Host interrupt
  output logic o_dsp_priority_irq              // DSP interrupt
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  hwsr_hpin_t pin1_reg, pin2_reg, prev_reg;
  logic [7:0] haddr_reg, haddr_next;
  logic [NCH-1:0][31:0] wr_host_reg, wr_host_next;
  logic [NCH-1:0][31:0] wr_dsp_reg, wr_dsp_next;
  logic [NCH-1:0][31:0] rd_host_reg, rd_host_next;
  logic [NCH-1:0][31:0] rd_dsp_reg, rd_dsp_next;
  logic [7:0] ad_reg, ad_next;
  logic oe_reg, oe_next;
  logic [15:0] drd_reg, drd_next;
  hwsr_ext_t ext_reg, ext_next;
  logic [NLINE-1:0] line_reg, line_next, loe_reg, loe_next;
  logic [31:0] lrx1_reg, lrx1_next, lrx2_reg, lrx2_next;
  logic [NCH-1:0] stat_reg, stat_next;
  logic hirq_reg, hirq_next, dirq_reg, dirq_next;
  logic [NCH-1:0][31:0] ch_word, ch_load;
  logic [NCH-1:0] ch_bit, ch_oe, ch_evt;
  logic [2:0] fsync;
  logic [1:0] area, darea;
  logic [2:0] hch, dch;
  logic [4:0] hbase, dbase;
  logic io_hit, dio_hit, ext_ok, ale_fall, wr_end, rd_on;
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync_reg <= '0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];
  // Line-side channels, one per word slot
  assign fsync = {i_tx_frame_sync, i_rx_frame_sync, i_tdm_frame_sync};
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    // Each side's write word feeds the line only when selected
    assign ch_load[g] = i_cfg[g].src_host ? wr_host_reg[g] : wr_dsp_reg[g];
    hwsr_chan #(
      .IS_TX(CH_IS_TX[g]),
      .AUDIO(CH_IS_AUDIO[g])
    ) u_ch (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_cfg(i_cfg[g]),
      .i_bit_stb(i_bit_stb),
      .i_fsync(fsync),
      .i_line(i_line),
      .i_load(ch_load[g]),
      .o_word(ch_word[g]),
      .o_bit(ch_bit[g]),
      .o_oe(ch_oe[g]),
      .o_evt(ch_evt[g])
    );
  end
  // Host strobes, DSP port, window decode and statuses
  always_comb
  begin
    ale_fall = prev_reg.ale & ~pin2_reg.ale;
    // Write taken as the strobe ends, data held on the bus then
    wr_end = ~prev_reg.wr_n & pin2_reg.wr_n & ~prev_reg.cs_n;
    rd_on = ~pin2_reg.rd_n & ~pin2_reg.cs_n;
    haddr_next = ale_fall ? prev_reg.ad : haddr_reg;
    area = haddr_reg[AREA_MSB:AREA_LSB];
    hch = haddr_reg[CH_MSB:CH_LSB];
    hbase = {haddr_reg[CH_LSB-1:0], 3'h0};
    io_hit = (area == AREA_IO) && !haddr_reg[IO_PAD_BIT];
    ext_ok = (area == AREA_COM) ||
             (area == AREA_LNK1 && i_host_owns_link_bank_first) ||
             (area == AREA_LNK2 && i_host_owns_link_bank_second);
    wr_host_next = wr_host_reg;
    wr_dsp_next = wr_dsp_reg;
    rd_host_next = rd_host_reg;
    rd_dsp_next = rd_dsp_reg;
    // Unused spots and banks not handed over answer zero
    ad_next = '0;
    if (io_hit && CH_RD[hch])
      ad_next = rd_host_reg[hch][hbase +: 8];
    else if (ext_ok)
      ad_next = i_ext_rdata;
    oe_next = rd_on;
    // Writes land in write words only, readback is untouched
    if (wr_end && io_hit && CH_WR[hch])
      wr_host_next[hch][hbase +: 8] = prev_reg.ad;
    ext_next.area = area;
    ext_next.addr = haddr_reg;
    ext_next.wdata = prev_reg.ad;
    ext_next.wr = wr_end && ext_ok;
    ext_next.rd = rd_on && ext_ok;
    // DSP reaches the same words through its own copies
    darea = i_dsp_addr[AREA_MSB:AREA_LSB];
    dch = i_dsp_addr[CH_MSB:CH_LSB];
    dbase = {i_dsp_addr[HALF_BIT], 4'h0};
    dio_hit = (darea == AREA_IO) && !i_dsp_addr[IO_PAD_BIT];
    if (i_dsp_wr && dio_hit && CH_WR[dch])
      wr_dsp_next[dch][dbase +: 16] = i_dsp_wdata;
    drd_next = drd_reg;
    if (i_dsp_rd)
      drd_next = (dio_hit && CH_RD[dch]) ? rd_dsp_reg[dch][dbase +: 16]
                                         : '0;
    line_next = '0;
    loe_next = '0;
    for (int c = 0; c < NCH; c++)
    begin
      // Each side gets its own copy of a finished word
      if (ch_evt[c])
      begin
        rd_host_next[c] = ch_word[c];
        rd_dsp_next[c] = ch_word[c];
      end
      if (ch_oe[c])
      begin
        line_next[i_cfg[c].line] = line_next[i_cfg[c].line] | ch_bit[c];
        loe_next[i_cfg[c].line] = 1'b1;
      end
    end
    lrx1_next = ch_load[CH_LRX1];
    lrx2_next = ch_load[CH_LRX2];
    // New events win over a clear in the same cycle
    stat_next = (stat_reg & ~i_status_clr) | ch_evt;
    hirq_next = |(stat_reg & i_host_irq_mask);
    dirq_next = |(stat_reg & i_dsp_irq_mask);
  end
  // Host pins cross in on two flops; the second and a one-clock delayed copy of it are read
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin1_reg <= HPIN_IDLE;
      pin2_reg <= HPIN_IDLE;
      prev_reg <= HPIN_IDLE;
      haddr_reg <= '0;
      wr_host_reg <= '0;
      wr_dsp_reg <= '0;
      rd_host_reg <= '0;
      rd_dsp_reg <= '0;
      ad_reg <= '0;
      oe_reg <= 1'b0;
      drd_reg <= '0;
      ext_reg <= '0;
      line_reg <= '0;
      loe_reg <= '0;
      lrx1_reg <= '0;
      lrx2_reg <= '0;
      stat_reg <= '0;
      hirq_reg <= 1'b0;
      dirq_reg <= 1'b0;
    end
    else
    begin
      pin1_reg <= {i_host_ale, i_host_rd_n, i_host_wr_n, i_host_cs_n,
                   i_host_ad};
      pin2_reg <= pin1_reg;
      prev_reg <= pin2_reg;
      haddr_reg <= haddr_next;
      wr_host_reg <= wr_host_next;
      wr_dsp_reg <= wr_dsp_next;
      rd_host_reg <= rd_host_next;
      rd_dsp_reg <= rd_dsp_next;
      ad_reg <= ad_next;
      oe_reg <= oe_next;
      drd_reg <= drd_next;
      ext_reg <= ext_next;
      line_reg <= line_next;
      loe_reg <= loe_next;
      lrx1_reg <= lrx1_next;
      lrx2_reg <= lrx2_next;
      stat_reg <= stat_next;
      hirq_reg <= hirq_next;
      dirq_reg <= dirq_next;
    end
  end
  assign o_host_ad = ad_reg;
  assign o_host_ad_oe = oe_reg;
  assign o_dsp_rdata = drd_reg;
  assign o_ext = ext_reg;
  assign o_line = line_reg;
  assign o_line_oe = loe_reg;
  assign o_link_rx_load_first = lrx1_reg;
  assign o_link_rx_load_second = lrx2_reg;
  assign o_status = stat_reg;
  assign o_host_priority_irq = hirq_reg;
  assign o_dsp_priority_irq = dirq_reg;
endmodule : hwsr_top

// *** src/hwsr_pkg.sv ***
// Purpose: Shared constants and types for the host window sample bank.
// Assumes: One core clock; line shifters run on the same clock.
// Notes: Channel order fixes the host and DSP offsets of each word.
package hwsr_pkg;
  // Window areas, taken from the two top address bits
  localparam logic [1:0] AREA_IO = 2'h0;
  localparam logic [1:0] AREA_COM = 2'h1;
  localparam logic [1:0] AREA_LNK1 = 2'h2;
  localparam logic [1:0] AREA_LNK2 = 2'h3;
  localparam int AREA_MSB = 7;
  localparam int AREA_LSB = 6;
  localparam int IO_PAD_BIT = 5;
  localparam int CH_MSB = 4;
  localparam int CH_LSB = 2;
  localparam int HALF_BIT = 1;
  // DSP sees the window at this base; port carries the low byte only
  localparam logic [15:0] DSP_WIN_BASE = 16'h3000;

  // Channel slots, four bytes each from offset 00h
  localparam int NCH = 8;
  localparam int CH_ARX1 = 0;
  localparam int CH_ARX2 = 1;
  localparam int CH_ATX1 = 2;
  localparam int CH_ATX2 = 3;
  localparam int CH_LRX1 = 4;
  localparam int CH_LTX1 = 5;
  localparam int CH_LRX2 = 6;
  localparam int CH_LTX2 = 7;
  localparam logic [NCH-1:0] CH_IS_TX = 8'hAC;
  localparam logic [NCH-1:0] CH_IS_AUDIO = 8'h0F;
  localparam logic [NCH-1:0] CH_RD = 8'hF3;
  localparam logic [NCH-1:0] CH_WR = 8'hFC;

  // Slot placement limits
  localparam logic [9:0] POS_FIRST = 10'h001;
  localparam logic [9:0] POS_IDLE = 10'h3FF;
  localparam logic [9:0] START_MAX = 10'h200;
  localparam logic [8:0] LEN_MIN = 9'h001;
  localparam logic [8:0] LEN_AUDIO_MAX = 9'h020;
  localparam logic [8:0] LEN_LINK_MAX = 9'h100;
  localparam logic [5:0] UNIT_MIN = 6'h01;
  localparam logic [5:0] UNIT_MAX = 6'h20;
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;

  // Frame sync selection and line numbering
  localparam logic [1:0] FS_TDM = 2'h0;
  localparam logic [1:0] FS_RX = 2'h1;
  localparam logic [1:0] FS_TX = 2'h2;
  localparam int NLINE = 4;

  // Placement of one channel on the lines
  typedef struct packed {
    logic [1:0] line;       // 0 srx,1 stx,2 up,3 down
    logic [1:0] fsel;       // Frame sync source
    logic [9:0] start;      // First bit, 1..512
    logic [8:0] len;        // Slot length in bits
    logic [5:0] icnt;       // Bits per transfer event
    logic frame_mode;       // Event on frame start
    logic src_host;         // Host word feeds the line
  } hwsr_chcfg_t;

  // Synchronised host pins
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic [7:0] ad;
  } hwsr_hpin_t;
  localparam hwsr_hpin_t HPIN_IDLE = 12'h700;

  // Access passed to the com area and link banks
  typedef struct packed {
    logic [1:0] area;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hwsr_ext_t;
endpackage : hwsr_pkg

// *** dv/hwsr_properties.sv ***
// Purpose: Port timing checks for the host window sample bank.
// Assumes: One clock; masks and ownership static during accesses.
// Notes: Bound to the top module from the bench.
`timescale 1ns/1ps
module hwsr_properties
  import hwsr_pkg::*;
(
  input wire logic i_clk,                      // Core clock
  input wire logic i_resetn,                   // Reset, low
  input wire logic i_host_rd_n,                // Read strobe
  input wire logic i_host_owns_link_bank_first, // Bank one owner
  input wire logic i_dsp_rd,                   // DSP read
  input wire logic [7:0] i_dsp_addr,           // DSP address
  input wire logic [NCH-1:0] i_status_clr,     // Clear pulses
  input wire logic [NCH-1:0] i_host_irq_mask,  // Host mask
  input wire logic [NCH-1:0] i_dsp_irq_mask,   // DSP mask
  input wire logic o_host_ad_oe,               // Bus drive
  input wire logic [15:0] o_dsp_rdata,         // DSP read half
  input wire hwsr_ext_t o_ext,                 // Forwarded access
  input wire logic [NCH-1:0] o_status,         // Statuses
  input wire logic o_host_priority_irq,        // Host irq
  input wire logic o_dsp_priority_irq          // DSP irq
);
  // Everything here lives in the core clock domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_reset_quiet:
    assert property ($rose(i_resetn) |-> o_status == '0 && !o_host_ad_oe)
    else $error("outputs active right after reset");
  chk_oe_after_rd:
    assert property ($rose(o_host_ad_oe) |-> !$past(i_host_rd_n, 2))
    else $error("bus driven without read strobe");
  chk_oe_release:
    assert property ($rose(i_host_rd_n) |-> ##4 !o_host_ad_oe)
    else $error("bus still driven after read");
  chk_bank_owned:
    assert property (o_ext.wr && o_ext.area == AREA_LNK1
      |-> i_host_owns_link_bank_first)
    else $error("write forwarded to unowned bank");
  chk_ext_area:
    assert property (o_ext.wr |-> o_ext.area == o_ext.addr[7:6]
      && o_ext.area != AREA_IO)
    else $error("forwarded area does not match address");
  chk_dsp_nonio:
    assert property (i_dsp_rd && i_dsp_addr[7:6] != AREA_IO
      |=> o_dsp_rdata == '0)
    else $error("DSP read outside channel area not zero");
  chk_dsp_hold:
    assert property (!i_dsp_rd |=> $stable(o_dsp_rdata))
    else $error("DSP read data moved without read");
  chk_status_sticky:
    assert property (($past(o_status) & ~o_status
      & ~$past(i_status_clr)) == '0)
    else $error("status dropped without clear");
  chk_host_irq:
    assert property (|(o_status & i_host_irq_mask) |=> o_host_priority_irq)
    else $error("host irq missing");
  chk_dsp_irq_off:
    assert property (!(|(o_status & i_dsp_irq_mask))
      |=> !o_dsp_priority_irq)
    else $error("DSP irq without masked status");

  // Main scenarios reached
  cover property (o_ext.wr);
  cover property ($rose(o_host_ad_oe));
  cover property ($rose(o_host_priority_irq));
endmodule : hwsr_properties

// *** dv/hwsr_host_model.sv ***
// Purpose: Host processor on the multiplexed byte bus.
// Assumes: Strobes move at falling edges, phases of several clocks.
// Notes: A released bus shows the inverse of the last byte driven.
`timescale 1ns/1ps
module hwsr_host_model
(
  input wire logic i_clk,          // Core clock
  input wire logic [7:0] i_dut_ad, // Device read byte
  input wire logic i_dut_oe,       // Device drives bus
  output logic [7:0] o_ad,         // Resolved bus level
  output logic o_ale = 1'b0,       // Address latch
  output logic o_cs_n = 1'b1,      // Chip select
  output logic o_wr_n = 1'b1,      // Write strobe
  output logic o_rd_n = 1'b1       // Read strobe
);
  logic drv = 1'b0;
  logic [7:0] val = 8'h00;
  int to_cnt = 0;

  // Bus level from both parties' enables
  assign o_ad = (i_dut_oe === 1'b1) ? i_dut_ad : (drv ? val : ~val);

  // Address phase, then write strobe for four clocks or read strobe held until answered or the 20-clock wait runs out
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'h00;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    o_ale = 1'b1;
    drv = 1'b1;
    val = a;
    repeat (3) @(negedge i_clk);
    o_ale = 1'b0;
    repeat (3) @(negedge i_clk);
    if (w)
    begin
      val = d;
      o_wr_n = 1'b0;
      repeat (4) @(negedge i_clk);
      o_wr_n = 1'b1;
      @(negedge i_clk);
    end
    else
    begin
      drv = 1'b0;
      o_rd_n = 1'b0;
      @(negedge i_clk);
      while (i_dut_oe !== 1'b1 && n < 20)
      begin
        n++;
        @(negedge i_clk);
      end
      if (i_dut_oe !== 1'b1)
        to_cnt++;
      q = i_dut_ad;
      o_rd_n = 1'b1;
    end
    o_cs_n = 1'b1;
    drv = 1'b0;
    repeat (6) @(negedge i_clk);
  endtask : xfer
endmodule : hwsr_host_model

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the host window sample bank.
// Assumes: All three frame syncs pulse together with bit one.
// Notes: Bits run every third clock so line lag is visible.
`timescale 1ns/1ps
module tb_top;
  import hwsr_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] host_ad, o_host_ad, dsp_addr = 8'h00, ext_rdata = 8'h00;
  logic o_host_ad_oe, cs_n, wr_n, rd_n, ale, own1 = 1'b0, own2 = 1'b0;
  logic dsp_wr = 1'b0, dsp_rd = 1'b0, stb = 1'b0, fs = 1'b0, lbit = 1'b0;
  logic hirq, dirq;
  logic [15:0] dsp_wdata = 16'h0000, dsp_rdata;
  logic [31:0] lr1, lr2;
  hwsr_ext_t ext;
  hwsr_chcfg_t [NCH-1:0] cfg;
  logic [3:0] line_in, line_out, line_oe;
  logic [NCH-1:0] status, clr = 8'h00, hmask = 8'h01, dmask = 8'h02;
  logic [7:0] ra [5] = '{8'h85, 8'hC5, 8'h4A, 8'h25, 8'h09};
  bit txq [$], txq2 [$];
  logic [15:0] ext_q [$];
  int n_errors = 0;
  int n_compared = 0;

  // 250 MHz core clock
  initial
  begin
    forever #2 i_clk = ~i_clk;
  end

  // Line level from the device's drive and the bench's bit
  assign line_in = (line_oe & line_out) | (~line_oe & {4{lbit}});

  hwsr_host_model host_u (.i_clk(i_clk), .i_dut_ad(o_host_ad),
    .i_dut_oe(o_host_ad_oe), .o_ad(host_ad), .o_ale(ale), .o_cs_n(cs_n),
    .o_wr_n(wr_n), .o_rd_n(rd_n));

  hwsr_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_host_ad(host_ad),
    .o_host_ad(o_host_ad), .o_host_ad_oe(o_host_ad_oe), .i_host_cs_n(cs_n),
    .i_host_wr_n(wr_n), .i_host_rd_n(rd_n), .i_host_ale(ale),
    .i_host_owns_link_bank_first(own1), .i_host_owns_link_bank_second(own2),
    .i_dsp_addr(dsp_addr), .i_dsp_wr(dsp_wr), .i_dsp_rd(dsp_rd),
    .i_dsp_wdata(dsp_wdata), .o_dsp_rdata(dsp_rdata), .o_ext(ext),
    .i_ext_rdata(ext_rdata), .i_cfg(cfg), .i_bit_stb(stb),
    .i_tdm_frame_sync(fs), .i_rx_frame_sync(fs), .i_tx_frame_sync(fs),
    .i_line(line_in), .o_line(line_out), .o_line_oe(line_oe),
    .o_link_rx_load_first(lr1), .o_link_rx_load_second(lr2),
    .o_status(status), .i_status_clr(clr), .i_host_irq_mask(hmask),
    .i_dsp_irq_mask(dmask), .o_host_priority_irq(hirq),
    .o_dsp_priority_irq(dirq));

  // Record every forwarded write
  always @(posedge i_clk)
    if (ext.wr === 1'b1)
      ext_q.push_back({ext.addr, ext.wdata});

  task automatic check(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic hwr32(input logic [7:0] a, input logic [31:0] w);
    logic [7:0] q;
    for (int k = 0; k < 4; k++)
      host_u.xfer(1'b1, a + 8'(k), w[8*k +: 8], q);
  endtask : hwr32

  task automatic hrd32(input logic [7:0] a, output logic [31:0] w);
    logic [7:0] q;
    for (int k = 0; k < 4; k++)
    begin
      host_u.xfer(1'b0, a + 8'(k), 8'h00, q);
      w[8*k +: 8] = q;
    end
  endtask : hrd32

  task automatic dsp(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge i_clk);
    dsp_addr = a;
    dsp_wr = w;
    dsp_rd = !w;
    dsp_wdata = d;
    @(negedge i_clk);
    dsp_wr = 1'b0;
    dsp_rd = 1'b0;
    q = dsp_rdata;
  endtask : dsp

  // Sixteen-bit frame, pattern fed MSB first, lines 3 and 2 collected
  task automatic frame(input logic [31:0] pat);
    txq = {};
    txq2 = {};
    for (int i = 1; i <= 16; i++)
    begin
      @(negedge i_clk);
      stb = 1'b1;
      fs = (i == 1);
      lbit = pat[32-i];
      @(negedge i_clk);
      stb = 1'b0;
      fs = 1'b0;
      @(negedge i_clk);
      if (line_oe[3] === 1'b1)
        txq.push_back(line_out[3]);
      if (line_oe[2] === 1'b1)
        txq2.push_back(line_out[2]);
    end
    repeat (4) @(negedge i_clk);
  endtask : frame

  task automatic complete_run;
    n_errors += host_u.to_cnt;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // Hang guard
  initial
  begin
    repeat (50000) @(posedge i_clk);
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    logic [31:0] tw, lw, p1, p2, w;
    logic [15:0] dq;
    logic [7:0] b, d, e;
    for (int c = 0; c < NCH; c++)
      cfg[c] = '{2'h1, FS_TDM, START_MAX, LEN_MIN, UNIT_MIN, 1'b0, 1'b1};
    cfg[0] = '{2'h0, FS_RX, 10'h003, 9'h008, 6'h08, 1'b0, 1'b0};
    cfg[1] = '{2'h0, FS_TDM, POS_FIRST, LEN_AUDIO_MAX, UNIT_MAX, 1'b1, 1'b0};
    cfg[2] = '{2'h3, FS_TX, 10'h005, 9'h008, 6'h08, 1'b0, 1'b1};
    cfg[3] = '{2'h2, FS_TDM, 10'h005, 9'h008, 6'h08, 1'b0, 1'b0};
    void'($urandom(32'hF6D1));
    tw = $urandom();
    lw = $urandom();
    p1 = $urandom();
    p2 = $urandom();
    {d, e} = 16'($urandom());
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_clk);
    hwr32(8'h08, tw);
    hwr32(8'h10, lw);
    hwr32(8'h00, ~tw);
    hwr32(8'h0C, ~tw);
    hwr32(8'h18, ~lw);
    dsp(1'b1, 8'h0C, tw[31:16], dq);
    check("link_rx_load", lw, lr1);
    check("link_rx_load2", ~lw, lr2);
    hrd32(8'h00, w);
    check("rx_after_write", 32'h0, w);
    frame(p1);
    check("status", 32'hF, {24'h0, status});
    check("irqs", 32'h3, {30'h0, hirq, dirq});
    clr = 8'hFF;
    @(negedge i_clk);
    clr = 8'h00;
    repeat (3) @(negedge i_clk);
    check("status_clr", 32'h0, {22'h0, status, hirq, dirq});
    hrd32(8'h00, w);
    check("rx_word", {24'h0, p1[29:22]}, w);
    dsp(1'b0, 8'h00, 16'h0000, dq);
    check("dsp_low", {24'h0, p1[29:22]}, {16'h0, dq});
    dsp(1'b0, 8'h02, 16'h0000, dq);
    check("dsp_high", 32'h0, {16'h0, dq});
    dsp(1'b1, 8'h00, 16'hFFFF, dq);
    frame(p2);
    w = 32'h0;
    foreach (txq[k])
      w = {w[30:0], txq[k]};
    check("tx_count", 32'h8, 32'(txq.size()));
    check("tx_bits", {24'h0, tw[7:0]}, w);
    w = 32'h0;
    foreach (txq2[k])
      w = {w[30:0], txq2[k]};
    check("dsp_tx_count", 32'h8, 32'(txq2.size()));
    check("dsp_tx_bits", {24'h0, tw[23:16]}, w);
    dsp(1'b0, 8'h00, 16'h0000, dq);
    check("dsp_rx_kept", {24'h0, p2[29:22]}, {16'h0, dq});
    dsp(1'b0, 8'h44, 16'h0000, dq);
    check("dsp_com", 32'h0, {16'h0, dq});
    // Bank one refused, bank two and com area forwarded
    own2 = 1'b1;
    ext_rdata = e;
    host_u.xfer(1'b1, 8'h85, d, b);
    host_u.xfer(1'b1, 8'hC5, d, b);
    check("ext_count", 32'h1, 32'(ext_q.size()));
    check("ext_entry", {16'h0, 8'hC5, d}, {16'h0, ext_q[0]});
    for (int k = 0; k < 5; k++)
    begin
      host_u.xfer(1'b0, ra[k], 8'h00, b);
      check("host_byte", (k == 1 || k == 2) ? {24'h0, e} : 32'h0,
        {24'h0, b});
    end
    complete_run();
  end
endmodule : tb_top

bind hwsr_top hwsr_properties chk_u (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_host_rd_n(i_host_rd_n),
  .i_host_owns_link_bank_first(i_host_owns_link_bank_first),
  .i_dsp_rd(i_dsp_rd), .i_dsp_addr(i_dsp_addr),
  .i_status_clr(i_status_clr), .i_host_irq_mask(i_host_irq_mask),
  .i_dsp_irq_mask(i_dsp_irq_mask), .o_host_ad_oe(o_host_ad_oe),
  .o_dsp_rdata(o_dsp_rdata), .o_ext(o_ext), .o_status(o_status),
  .o_host_priority_irq(o_host_priority_irq),
  .o_dsp_priority_irq(o_dsp_priority_irq));
